// >>> include/slc_pkg.sv
// Summary of operation
// - Pin threshold at reset, select bit picks DAC
// - DAC threshold from register, zero never flags
// - Flag loss when level below active threshold
// - Hysteresis defaults to three dB
// - Hysteresis programmable zero to seven dB
// - Selectable push-pull or open-drain, selectable polarity
// - Limiter bit disables offset cancellation loop
// - Detected level readable as binary register
// - Manual bandwidth settings override automatic loop
// - Reset returns all registers to defaults
`default_nettype none
package slc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LEVEL    = 8'h0a;
    localparam logic [7:0] ADDR_LOSS_CFG = 8'h10;
    localparam logic [7:0] ADDR_LOSS_THR = 8'h11;
    localparam logic [7:0] ADDR_LIM_CFG  = 8'h12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LOSS_SRC_BIT  = 0;
    localparam int LOSS_HYST_LSB = 1;
    localparam int LOSS_HYST_MSB = 3;
    localparam int LOSS_PP_BIT   = 4;
    localparam int LOSS_POL_BIT  = 5;
    localparam int LIM_OFS_BIT   = 0;
    localparam int LIM_BWM_BIT   = 1;
    localparam int LIM_BW_LSB    = 2;
    localparam int LIM_BW_MSB    = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LOSS_CFG_RST = 8'h06;
    localparam logic [7:0] LOSS_THR_RST = 8'h00;
    localparam logic [7:0] LIM_CFG_RST  = 8'h00;
    localparam logic [7:0] LEVEL_RST    = 8'h00;

    // ------------------------------------------------------------
    // Serial bus and comparator constants
    // ------------------------------------------------------------
    // Bus address value is arbitrary
    localparam logic [6:0] DEV_ADDR    = 7'h2a;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    // Level codes per dB of hysteresis, a plain default
    localparam logic [9:0] HYST_STEP   = 10'h004;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } slc_wr_t;

    typedef struct packed {
        logic out;
        logic oe;
    } slc_pin_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'h0,
        ST_ADDR      = 3'h1,
        ST_ADDR_ACK  = 3'h2,
        ST_WRITE     = 3'h3,
        ST_WRITE_ACK = 3'h4,
        ST_READ      = 3'h5,
        ST_READ_ACK  = 3'h6
    } slc_i2c_state_t;

endpackage : slc_pkg
`default_nettype wire

// >>> tb/slc_i2c_master.sv
`default_nettype none
module slc_i2c_master (
    // Clock
    input  wire logic              sys_clk,
    // Bus pins
    input  wire slc_pkg::slc_pin_t sda_pin,
    output logic                   scl_in,
    output logic                   sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import slc_pkg::*;
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    // Pull-up wins unless a party pulls low, so a released line reads 1
    assign scl_in = scl_drv;
    assign sda_in = sda_drv & ~(sda_pin.oe & ~sda_pin.out);

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // Six cycles each side of a bus clock edge keeps setup and hold safe
    task automatic bit_io(input logic b, output logic r);
        tick(6);
        sda_drv <= b;
        tick(6);
        scl_drv <= 1'b1;
        tick(6);
        r = sda_in;
        tick(6);
        scl_drv <= 1'b0;
    endtask : bit_io
    // Also serves as repeated start from a low clock
    task automatic start_c;
        tick(6);
        sda_drv <= 1'b1;
        tick(6);
        scl_drv <= 1'b1;
        tick(6);
        sda_drv <= 1'b0;
        tick(6);
        scl_drv <= 1'b0;
    endtask : start_c
    task automatic stop_c;
        tick(6);
        sda_drv <= 1'b0;
        tick(6);
        scl_drv <= 1'b1;
        tick(6);
        sda_drv <= 1'b1;
        tick(6);
    endtask : stop_c
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ak, ack);
    endtask : xfer
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic nack);
        logic [7:0] x;
        logic       a;
        logic       b;
        logic       c;
        start_c();
        xfer({DEV_ADDR, 1'b0}, 1'b1, x, a);
        xfer(ptr, 1'b1, x, b);
        xfer(d, 1'b1, x, c);
        stop_c();
        nack = a | b | c;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic nack);
        logic [7:0] x;
        logic       a;
        logic       b;
        logic       c;
        start_c();
        xfer({DEV_ADDR, 1'b0}, 1'b1, x, a);
        xfer(ptr, 1'b1, x, b);
        start_c();
        xfer({DEV_ADDR, 1'b1}, 1'b1, x, c);
        xfer(8'hff, 1'b1, d, x[0]);
        stop_c();
        nack = a | b | c;
    endtask : rd_reg
    task automatic probe(input logic [6:0] dev, output logic nack);
        logic [7:0] x;
        start_c();
        xfer({dev, 1'b0}, 1'b1, x, nack);
        stop_c();
    endtask : probe
endmodule : slc_i2c_master
`default_nettype wire

// >>> tb/slc_signal_loss_detect_config_test.sv
`default_nettype none
module slc_signal_loss_detect_config_test;
    timeunit 1ns;
    timeprecision 1ps;
    import slc_pkg::*;
    localparam int LIMIT = 60000;
    logic       sys_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] level_detect = 8'h00;
    logic [7:0] pin_threshold = 8'h40;
    logic       scl_in, sda_in, flag, ocd, bwe, nack, lvl;
    logic [7:0] thr, rd;
    logic [3:0] bws;
    slc_pin_t   sda_pin, loss_pin;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    slc_signal_loss_detect_config slc_signal_loss_detect_config_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
        .sda_pin(sda_pin), .level_detect(level_detect), .pin_threshold(pin_threshold),
        .active_threshold(thr), .signal_loss_flag_pin(loss_pin), .signal_loss_flag(flag),
        .offset_cancel_disable(ocd), .bw_manual_en(bwe), .bw_manual_setting(bws));
    slc_i2c_master slc_i2c_master_inst (
        .sys_clk(sys_clk), .sda_pin(sda_pin), .scl_in(scl_in), .sda_in(sda_in));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // A hung bus transfer ends the run here
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            $display("MISMATCH at %0t: timeout", $time);
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        slc_i2c_master_inst.wr_reg(a, d, nack);
        check({7'h0, nack}, 8'h00, "write acknowledged");
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
        slc_i2c_master_inst.rd_reg(a, rd, nack);
        check({7'h0, nack}, 8'h00, "read acknowledged");
        check(rd, e, what);
    endtask : rdchk
    // Comparator and pin settle within three edges of an input change
    task automatic drive(input logic [7:0] lv);
        @(posedge sys_clk);
        level_detect <= lv;
        repeat (4) @(posedge sys_clk);
    endtask : drive
    task automatic pin(input logic f, input logic [1:0] ep);
        check({7'h0, flag}, {7'h0, f}, "loss flag");
        check({6'h0, loss_pin}, {6'h0, ep}, "loss pin out and enable");
    endtask : pin
    task automatic defaults;
        rdchk(ADDR_LOSS_CFG, 8'h06, "loss cfg default");
        rdchk(ADDR_LOSS_THR, 8'h00, "threshold default");
        rdchk(ADDR_LIM_CFG, 8'h00, "limiter default");
        check(thr, 8'h40, "pin threshold in use");
        check({2'h0, bws, bwe, ocd}, 8'h00, "limiter outputs default");
        $display("Test defaults done");
    endtask : defaults

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        defaults();
        drive(8'h50);
        pin(1'b0, 2'b00);
        drive(8'h3f);
        pin(1'b1, 2'b01);
        drive(8'h4b);
        pin(1'b1, 2'b01);
        drive(8'h4c);
        pin(1'b0, 2'b00);
        ce <= 1'b0;
        drive(8'h00);
        pin(1'b0, 2'b00);
        ce <= 1'b1;
        drive(8'h00);
        pin(1'b1, 2'b01);
        $display("Test pin threshold done");
        wr(ADDR_LOSS_CFG, 8'h07);
        drive(8'h00);
        check(thr, 8'h00, "register threshold in use");
        pin(1'b0, 2'b00);
        wr(ADDR_LOSS_THR, 8'h80);
        check(thr, 8'h80, "register threshold value");
        for (int h = 0; h < 8; h++) begin
            wr(ADDR_LOSS_CFG, {4'h0, 3'(h), 1'b1});
            drive(8'h7f);
            pin(1'b1, 2'b01);
            drive(8'h7f + 8'(4 * h));
            pin(1'b1, 2'b01);
            drive(8'h80 + 8'(4 * h));
            pin(1'b0, 2'b00);
        end
        $display("Test hysteresis done");
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_LOSS_CFG, {2'b11, 2'(s), 4'h1});
            rdchk(ADDR_LOSS_CFG, {2'b11, 2'(s), 4'h1}, "loss cfg readback");
            for (int f = 0; f < 2; f++) begin
                drive((f == 1) ? 8'h70 : 8'h90);
                lvl = (f == 1) ? s[1] : !s[1];
                pin(f[0], s[0] ? {lvl, 1'b1} : {1'b0, !lvl});
            end
        end
        $display("Test output style done");
        wr(ADDR_LIM_CFG, 8'h2b);
        check({2'h0, bws, bwe, ocd}, 8'h2b, "limiter outputs");
        rdchk(ADDR_LIM_CFG, 8'h2b, "limiter readback");
        drive(8'h5a);
        rdchk(ADDR_LEVEL, 8'h5a, "level readout");
        wr(ADDR_LEVEL, 8'h11);
        rdchk(ADDR_LEVEL, 8'h5a, "readout ignores writes");
        rdchk(8'h20, 8'h00, "unmapped read");
        slc_i2c_master_inst.probe(7'h2b, nack);
        check({7'h0, nack}, 8'h01, "foreign address refused");
        $display("Test limiter and readout done");
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        defaults();
        print_verdict();
    end
endmodule : slc_signal_loss_detect_config_test
`default_nettype wire

// >>> verilog/slc_loss_compare.sv
`default_nettype none
module slc_loss_compare (
    // Clock and control
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // Comparison inputs
    input  wire logic [7:0] level,
    input  wire logic [7:0] threshold,
    input  wire logic [2:0] hyst_db,
    // Result
    output logic            loss
);
    import slc_pkg::*;

    logic [9:0] release_level;

    // Release point sits above the threshold by the hysteresis span
    assign release_level = {2'b00, threshold} + (10'(hyst_db) * HYST_STEP);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            loss <= 1'b0;
        end else if (ce) begin
            if (threshold == 8'h00) begin
                loss <= 1'b0;
            end else if (!loss && (level < threshold)) begin
                loss <= 1'b1;
            end else if (loss && ({2'b00, level} >= release_level)) begin
                loss <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_zero_thr_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && threshold == 8'h00 |=> !loss)
        else $error("loss flagged with zero threshold");

    a_loss_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && threshold != 8'h00 && level < threshold |=> loss)
        else $error("loss not flagged below threshold");

    a_hyst_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && loss && threshold != 8'h00 && {2'b00, level} < release_level |=> loss)
        else $error("loss released inside hysteresis band");

    a_loss_release: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && loss && {2'b00, level} >= release_level |=> !loss)
        else $error("loss not released above band");

    c_loss_rise: cover property (@(posedge sys_clk) disable iff (!rst_b)
        !loss ##1 loss);

endmodule : slc_loss_compare
`default_nettype wire

// >>> verilog/slc_pin_sync.sv
`default_nettype none
module slc_pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // Clock and control
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Pins
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import slc_pkg::*;

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ------------------------------------------------------------
    // Per-bit agreement filter; a one-cycle glitch never passes
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
                dout[i] <= INIT[i];
            end else if (ce && (s2[i] == s3[i])) begin
                dout[i] <= s3[i];
            end
        end
    end

endmodule : slc_pin_sync
`default_nettype wire

// >>> verilog/slc_signal_loss_detect_config.sv
`default_nettype none
module slc_signal_loss_detect_config (
    // Clock, reset and enable
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // Two-wire serial bus
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output var  slc_pkg::slc_pin_t sda_pin,
    // Level detector and threshold pin
    input  wire logic [7:0]        level_detect,
    input  wire logic [7:0]        pin_threshold,
    output logic      [7:0]        active_threshold,
    // Loss indication
    output var  slc_pkg::slc_pin_t signal_loss_flag_pin,
    output logic                   signal_loss_flag,
    // Limiter controls
    output logic                   offset_cancel_disable,
    output logic                   bw_manual_en,
    output logic      [3:0]        bw_manual_setting
);
    import slc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]     bus_sync;
    logic           scl_s;
    logic           sda_s;
    logic           scl_q;
    logic           sda_q;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    slc_i2c_state_t bus_state;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic [7:0]     tx;
    logic [7:0]     ptr;
    logic           ptr_valid;
    logic           read_mode;
    logic           nack;
    slc_wr_t        wr_req;
    slc_pin_t       next_sda;
    logic [7:0]     loss_cfg;
    logic [7:0]     loss_thr;
    logic [7:0]     lim_cfg;
    logic [7:0]     level_readout;
    logic           pin_level;

    // Register read decode, shared by first and following read bytes
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        case (addr)
            ADDR_LEVEL:    reg_read = level_readout;
            ADDR_LOSS_CFG: reg_read = loss_cfg;
            ADDR_LOSS_THR: reg_read = loss_thr;
            ADDR_LIM_CFG:  reg_read = lim_cfg;
            default:       reg_read = 8'h00;
        endcase
    endfunction : reg_read

    // ------------------------------------------------------------
    // Bus pin conditioning
    // ------------------------------------------------------------
    slc_pin_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_bus_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .din     ({scl_in, sda_in}),
        .dout    (bus_sync)
    );

    assign scl_s     = bus_sync[1];
    assign sda_s     = bus_sync[0];
    assign scl_rise  = scl_s && !scl_q;
    assign scl_fall  = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop  = scl_s && scl_q && !sda_q && sda_s;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // Serial bus engine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bus_state <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            tx        <= 8'h00;
            ptr       <= 8'h00;
            ptr_valid <= 1'b0;
            read_mode <= 1'b0;
            nack      <= 1'b0;
            wr_req    <= '0;
        end else if (ce) begin
            wr_req.valid <= 1'b0;
            if (bus_start) begin
                bus_state <= ST_ADDR;
                bit_cnt   <= 4'h0;
            end else if (bus_stop) begin
                bus_state <= ST_IDLE;
            end else begin
                case (bus_state)
                    ST_ADDR, ST_WRITE: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && (bit_cnt == BYTE_BITS)) begin
                            bit_cnt <= 4'h0;
                            if (bus_state == ST_ADDR) begin
                                if (shift[7:1] == DEV_ADDR) begin
                                    read_mode <= shift[0];
                                    bus_state <= ST_ADDR_ACK;
                                    if (!shift[0]) begin
                                        ptr_valid <= 1'b0;
                                    end
                                end else begin
                                    bus_state <= ST_IDLE;
                                end
                            end else begin
                                bus_state <= ST_WRITE_ACK;
                                if (!ptr_valid) begin
                                    ptr       <= shift;
                                    ptr_valid <= 1'b1;
                                end else begin
                                    wr_req.valid <= 1'b1;
                                    wr_req.addr  <= ptr;
                                    wr_req.data  <= shift;
                                    ptr          <= ptr + 8'h01;
                                end
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_WRITE_ACK: begin
                        if (scl_fall) begin
                            if (read_mode) begin
                                bus_state <= ST_READ;
                                tx        <= reg_read(ptr);
                                ptr       <= ptr + 8'h01;
                            end else begin
                                bus_state <= ST_WRITE;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt == (BYTE_BITS - 4'h1)) begin
                                bus_state <= ST_READ_ACK;
                                bit_cnt   <= 4'h0;
                            end else begin
                                tx      <= {tx[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    ST_READ_ACK: begin
                        if (scl_rise) begin
                            nack <= sda_s;
                        end else if (scl_fall) begin
                            if (nack) begin
                                bus_state <= ST_IDLE;
                            end else begin
                                bus_state <= ST_READ;
                                tx        <= reg_read(ptr);
                                ptr       <= ptr + 8'h01;
                            end
                        end
                    end
                    default: begin
                        bus_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Data line is open drain: only ever pulled low
    always_comb begin
        next_sda.out = 1'b0;
        next_sda.oe  = 1'b0;
        case (bus_state)
            ST_ADDR_ACK:  next_sda.oe = 1'b1;
            ST_WRITE_ACK: next_sda.oe = 1'b1;
            ST_READ:      next_sda.oe = !tx[7];
            default:      next_sda.oe = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sda_pin <= '0;
        end else if (ce) begin
            sda_pin <= next_sda;
        end
    end

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    // Writes to the readout or unmapped offsets are dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            loss_cfg      <= LOSS_CFG_RST;
            loss_thr      <= LOSS_THR_RST;
            lim_cfg       <= LIM_CFG_RST;
            level_readout <= LEVEL_RST;
        end else if (ce) begin
            level_readout <= level_detect;
            if (wr_req.valid) begin
                case (wr_req.addr)
                    ADDR_LOSS_CFG: loss_cfg <= wr_req.data;
                    ADDR_LOSS_THR: loss_thr <= wr_req.data;
                    ADDR_LIM_CFG:  lim_cfg  <= wr_req.data;
                    default:       loss_cfg <= loss_cfg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Threshold source and comparator
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            active_threshold <= 8'h00;
        end else if (ce) begin
            active_threshold <= loss_cfg[LOSS_SRC_BIT] ? loss_thr : pin_threshold;
        end
    end

    slc_loss_compare u_compare (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .level     (level_detect),
        .threshold (active_threshold),
        .hyst_db   (loss_cfg[LOSS_HYST_MSB:LOSS_HYST_LSB]),
        .loss      (signal_loss_flag)
    );

    // ------------------------------------------------------------
    // Loss pin and limiter controls
    // ------------------------------------------------------------
    // Polarity bit clear means the pin goes low on loss
    assign pin_level = !(signal_loss_flag ^ loss_cfg[LOSS_POL_BIT]);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            signal_loss_flag_pin <= '0;
        end else if (ce) begin
            if (loss_cfg[LOSS_PP_BIT]) begin
                signal_loss_flag_pin.out <= pin_level;
                signal_loss_flag_pin.oe  <= 1'b1;
            end else begin
                signal_loss_flag_pin.out <= 1'b0;
                signal_loss_flag_pin.oe  <= !pin_level;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            offset_cancel_disable <= 1'b0;
            bw_manual_en          <= 1'b0;
            bw_manual_setting     <= 4'h0;
        end else if (ce) begin
            offset_cancel_disable <= lim_cfg[LIM_OFS_BIT];
            bw_manual_en          <= lim_cfg[LIM_BWM_BIT];
            bw_manual_setting     <= lim_cfg[LIM_BW_MSB:LIM_BW_LSB];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_src_pin: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && !loss_cfg[LOSS_SRC_BIT] |=> active_threshold == $past(pin_threshold))
        else $error("pin threshold not selected");

    a_src_dac: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && loss_cfg[LOSS_SRC_BIT] |=> active_threshold == $past(loss_thr))
        else $error("register threshold not selected");

    a_od_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && !loss_cfg[LOSS_PP_BIT] && !loss_cfg[LOSS_POL_BIT]
        |=> !signal_loss_flag_pin.out && signal_loss_flag_pin.oe == $past(signal_loss_flag))
        else $error("open drain active low drive wrong");

    a_pp_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && loss_cfg[LOSS_PP_BIT]
        |=> signal_loss_flag_pin.oe
            && signal_loss_flag_pin.out == ($past(signal_loss_flag) ~^ $past(loss_cfg[5])))
        else $error("push pull drive wrong");

    a_offset_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && wr_req.valid && wr_req.addr == ADDR_LIM_CFG ##1 ce
        |=> offset_cancel_disable == $past(wr_req.data[0], 2))
        else $error("offset disable not following write");

    a_bw_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && wr_req.valid && wr_req.addr == ADDR_LIM_CFG ##1 ce
        |=> bw_manual_en == $past(wr_req.data[1], 2))
        else $error("bandwidth override not following write");

    a_readout_track: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce |=> level_readout == $past(level_detect))
        else $error("level readout stale");

    a_reset_default: assert property (@(posedge sys_clk)
        !rst_b |=> loss_cfg == LOSS_CFG_RST && loss_thr == LOSS_THR_RST
                   && loss_cfg[LOSS_HYST_MSB:LOSS_HYST_LSB] == 3'h3 && !signal_loss_flag)
        else $error("reset defaults wrong");

    a_unmapped_drop: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && wr_req.valid && wr_req.addr == ADDR_LEVEL |=> $stable(loss_cfg) && $stable(lim_cfg))
        else $error("write to readout disturbed config");

    c_dac_select: cover property (@(posedge sys_clk) disable iff (!rst_b)
        loss_cfg[LOSS_SRC_BIT] && signal_loss_flag);

    c_read_byte: cover property (@(posedge sys_clk) disable iff (!rst_b)
        bus_state == ST_READ ##[1:400] bus_state == ST_READ_ACK);

    c_reg_write: cover property (@(posedge sys_clk) disable iff (!rst_b)
        wr_req.valid && wr_req.addr == ADDR_LOSS_CFG);

endmodule : slc_signal_loss_detect_config
`default_nettype wire
